// File: shared/cwg_pkg.sv
// Purpose: shared constants and types for the complementary wave generator
// Assumes: single clock, synchronous active-high reset
// Notes: dead-band counts are in generator clock cycles
package cwg_pkg;
  localparam int DB_W = 6;
  localparam int SRC_W = 4;
  localparam logic [DB_W-1:0] DB_RESET = 6'h00;
  localparam logic [DB_W-1:0] DB_ONE = 6'h01;
  localparam logic SHUTDOWN_RESET = 1'b1;
  localparam logic OUT_RESET = 1'b0;
  localparam logic KEEP_RESET = 1'b0;
  localparam logic EDGE_RESET = 1'b0;
  typedef enum logic [1:0] {
    ST_OFF,
    ST_SHUT,
    ST_WAIT_EDGE,
    ST_RUN
  } cwg_state_t;
endpackage

// File: design/cwg_deadband.sv
// Purpose: one dead-band delay on a rising edge of a drive request
// Assumes: count of zero means no extra delay
// Notes: output falls at once when the request falls
`timescale 1ns/100ps
module cwg_deadband (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic active,
  input wire logic req,
  input wire logic [cwg_pkg::DB_W-1:0] delay,
  // delayed drive
  output logic drive
);
  logic [cwg_pkg::DB_W-1:0] count;
  logic [cwg_pkg::DB_W-1:0] next_count;
  logic next_drive;

  always_comb begin
    next_count = count;
    next_drive = 1'b0;
    if (active && req) begin
      if (drive) begin
        next_drive = 1'b1;
      end else if (count >= delay) begin
        next_drive = 1'b1;
      end else begin
        next_count = count + cwg_pkg::DB_ONE;
      end
    end else begin
      next_count = cwg_pkg::DB_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count <= cwg_pkg::DB_RESET;
      drive <= cwg_pkg::OUT_RESET;
    end else begin
      count <= next_count;
      drive <= next_drive;
    end
  end
endmodule

// File: design/complementary_wave_gen.sv
// Purpose: complementary wave generator with auto-shutdown and restart
// Assumes: CLOCK is the generator's own selected clock
// Notes: pin direction handling is done by software outside this block
`timescale 1ns/100ps
// Functional notes
// R1: runs from own clock, also during sleep
// R2: keeps fast oscillator requested during sleep
// R3: software sets pins input before enabling
// R4: software programs dead-bands, shutdown setup while disabled
// R5: software sets polarity, enables before enable bit
// R6: auto-restart enable clears shutdown flag automatically
// R7: shutdown drives outputs to override levels
// R8: polarity never applies to override levels
// R9: auto-restart bit selects restart method
// R10: software clear accepted only when sources low
// R11: auto-restart clears flag when sources low
// R12: overrides hold until next input rising edge
// R13: any selected shutdown source sets flag
// R14: dead-band delays rising and complementary edges
module complementary_wave_gen (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // control
  input wire logic GENERATOR_ENABLE_BIT,
  input wire logic AUTO_RESTART_ENABLE,
  input wire logic OVERRIDE_LEVEL_A,
  input wire logic OVERRIDE_LEVEL_B,
  input wire logic POLARITY_A,
  input wire logic POLARITY_B,
  input wire logic OUTPUT_ENABLE_A,
  input wire logic OUTPUT_ENABLE_B,
  input wire logic [cwg_pkg::DB_W-1:0] RISE_DEADBAND_REG,
  input wire logic [cwg_pkg::DB_W-1:0] FALL_DEADBAND_REG,
  input wire logic FAST_OSC_SELECTED,
  // shutdown flag access
  input wire logic SHUTDOWN_SET_WRITE,
  input wire logic SHUTDOWN_CLEAR_WRITE,
  // sources
  input wire logic INPUT_SOURCE,
  input wire logic INPUT_ACTIVE,
  input wire logic [cwg_pkg::SRC_W-1:0] SHUTDOWN_SOURCES,
  input wire logic [cwg_pkg::SRC_W-1:0] SHUTDOWN_SELECT,
  // outputs
  output logic WAVE_OUTPUT_A,
  output logic WAVE_OUTPUT_B,
  output logic SHUTDOWN_ACTIVE_FLAG,
  output logic FAST_OSC_KEEP
);
  cwg_pkg::cwg_state_t state;
  cwg_pkg::cwg_state_t next_state;
  logic next_flag;
  logic input_prev;
  logic next_out_a;
  logic next_out_b;
  logic next_keep;
  logic shut_cond;
  logic rise;
  logic run;
  logic drive_a;
  logic drive_b;
  logic next_input_prev;
  logic pins_off;
  logic hold_override;

  function automatic logic any_selected(input logic [cwg_pkg::SRC_W-1:0] src,
                                        input logic [cwg_pkg::SRC_W-1:0] sel);
    any_selected = |(src & sel);
  endfunction

  // level of one pin: off, override or gated wave
  function automatic logic pin_level(input logic off,
                                     input logic hold,
                                     input logic level,
                                     input logic enable,
                                     input logic drive,
                                     input logic invert);
    if (off) begin
      pin_level = 1'b0;
    end else if (hold) begin
      pin_level = level;
    end else begin
      pin_level = enable & (drive ^ invert);
    end
  endfunction

  assign shut_cond = any_selected(SHUTDOWN_SOURCES, SHUTDOWN_SELECT);
  assign rise = INPUT_SOURCE & ~input_prev;
  assign run = (state == cwg_pkg::ST_RUN);
  assign pins_off = !GENERATOR_ENABLE_BIT;
  assign hold_override = !run || next_flag;

  // dead-band on each edge
  cwg_deadband u_db_a ( // R14
    .clk(CLOCK),
    .rst(RESET),
    .active(run),
    .req(INPUT_SOURCE),
    .delay(RISE_DEADBAND_REG),
    .drive(drive_a)
  );

  cwg_deadband u_db_b ( // R14
    .clk(CLOCK),
    .rst(RESET),
    .active(run),
    .req(~INPUT_SOURCE),
    .delay(FALL_DEADBAND_REG),
    .drive(drive_b)
  );

  // shutdown flag
  always_comb begin
    next_flag = SHUTDOWN_ACTIVE_FLAG;
    if (shut_cond || SHUTDOWN_SET_WRITE) begin
      next_flag = 1'b1; // R13
    end else if (AUTO_RESTART_ENABLE) begin
      next_flag = 1'b0; // R6 R9 R11
    end else if (SHUTDOWN_CLEAR_WRITE) begin
      next_flag = 1'b0; // R9 R10
    end
  end

  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      cwg_pkg::ST_OFF: begin
        if (GENERATOR_ENABLE_BIT) begin
          next_state = cwg_pkg::ST_SHUT;
        end
      end
      cwg_pkg::ST_SHUT: begin
        if (!next_flag) begin
          next_state = cwg_pkg::ST_WAIT_EDGE;
        end
      end
      cwg_pkg::ST_WAIT_EDGE: begin
        if (next_flag) begin
          next_state = cwg_pkg::ST_SHUT;
        end else if (rise) begin
          next_state = cwg_pkg::ST_RUN; // R12
        end
      end
      cwg_pkg::ST_RUN: begin
        if (next_flag) begin
          next_state = cwg_pkg::ST_SHUT; // R13
        end
      end
      default: begin
        next_state = cwg_pkg::ST_OFF;
      end
    endcase
    if (!GENERATOR_ENABLE_BIT) begin
      next_state = cwg_pkg::ST_OFF;
    end
  end

  // input edge history
  always_comb begin
    next_input_prev = INPUT_SOURCE;
  end

  // oscillator request in sleep
  always_comb begin
    next_keep = GENERATOR_ENABLE_BIT && INPUT_ACTIVE && FAST_OSC_SELECTED; // R2
  end

  // output drive, override shown from enable on
  always_comb begin
    next_out_a = pin_level(pins_off, hold_override, OVERRIDE_LEVEL_A,
                           OUTPUT_ENABLE_A, drive_a, POLARITY_A); // R7 R8 R12
    next_out_b = pin_level(pins_off, hold_override, OVERRIDE_LEVEL_B,
                           OUTPUT_ENABLE_B, drive_b, POLARITY_B); // R7 R8 R12
  end

  // sequencing register, generator clock only
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state <= cwg_pkg::ST_OFF;
    end else begin
      state <= next_state; // R1
    end
  end

  // shutdown flag register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      SHUTDOWN_ACTIVE_FLAG <= cwg_pkg::SHUTDOWN_RESET;
    end else begin
      SHUTDOWN_ACTIVE_FLAG <= next_flag;
    end
  end

  // input edge register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      input_prev <= cwg_pkg::EDGE_RESET;
    end else begin
      input_prev <= next_input_prev;
    end
  end

  // oscillator request register
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      FAST_OSC_KEEP <= cwg_pkg::KEEP_RESET;
    end else begin
      FAST_OSC_KEEP <= next_keep;
    end
  end

  // output registers
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      WAVE_OUTPUT_A <= cwg_pkg::OUT_RESET;
      WAVE_OUTPUT_B <= cwg_pkg::OUT_RESET;
    end else begin
      WAVE_OUTPUT_A <= next_out_a;
      WAVE_OUTPUT_B <= next_out_b;
    end
  end
endmodule

// File: testbench/cwg_power_stage.sv
// Purpose: power stage load on the two drive pins
// Assumes: both pins high together is a short
// Notes: short flag is sticky
`timescale 1ns/100ps
module cwg_power_stage (
  // pins
  input wire logic clk,
  input wire logic drv_a,
  input wire logic drv_b,
  // status
  output logic shoot
);
  initial shoot = 1'b0;
  always @(posedge clk) if (drv_a && drv_b) shoot <= 1'b1;
endmodule

// File: testbench/cwg_chk.sv
// Purpose: port checks of the generator
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/100ps
module cwg_chk (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // control
  input wire logic GENERATOR_ENABLE_BIT,
  input wire logic AUTO_RESTART_ENABLE,
  input wire logic OVERRIDE_LEVEL_A,
  input wire logic OVERRIDE_LEVEL_B,
  input wire logic FAST_OSC_SELECTED,
  input wire logic INPUT_ACTIVE,
  input wire logic SHUTDOWN_SET_WRITE,
  input wire logic SHUTDOWN_CLEAR_WRITE,
  input wire logic [cwg_pkg::SRC_W-1:0] SHUTDOWN_SOURCES,
  input wire logic [cwg_pkg::SRC_W-1:0] SHUTDOWN_SELECT,
  // outputs
  input wire logic WAVE_OUTPUT_A,
  input wire logic WAVE_OUTPUT_B,
  input wire logic SHUTDOWN_ACTIVE_FLAG,
  input wire logic FAST_OSC_KEEP
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  wire hit = |(SHUTDOWN_SOURCES & SHUTDOWN_SELECT);
  wire sw = !AUTO_RESTART_ENABLE;
  wire want = GENERATOR_ENABLE_BIT && INPUT_ACTIVE && FAST_OSC_SELECTED;
  a_shut_override: assert property (GENERATOR_ENABLE_BIT && hit |=>
    WAVE_OUTPUT_A == $past(OVERRIDE_LEVEL_A) && WAVE_OUTPUT_B == $past(OVERRIDE_LEVEL_B))
    else $error("override not shown");
  a_source_sets: assert property (hit |=> SHUTDOWN_ACTIVE_FLAG)
    else $error("flag not set by source");
  a_clear_taken: assert property (
    sw && SHUTDOWN_CLEAR_WRITE && !hit && !SHUTDOWN_SET_WRITE |=> !SHUTDOWN_ACTIVE_FLAG)
    else $error("clear ignored");
  a_flag_holds: assert property (
    sw && !SHUTDOWN_CLEAR_WRITE && SHUTDOWN_ACTIVE_FLAG |=> SHUTDOWN_ACTIVE_FLAG)
    else $error("flag dropped");
  a_auto_clear: assert property (
    AUTO_RESTART_ENABLE && !hit && !SHUTDOWN_SET_WRITE |=> !SHUTDOWN_ACTIVE_FLAG)
    else $error("no auto clear");
  a_set_write: assert property (SHUTDOWN_SET_WRITE |=> SHUTDOWN_ACTIVE_FLAG)
    else $error("set write lost");
  a_hold_override: assert property ($fell(SHUTDOWN_ACTIVE_FLAG) &&
    $past(GENERATOR_ENABLE_BIT) && $past(GENERATOR_ENABLE_BIT, 2) && !$past(RESET, 2)
    |-> WAVE_OUTPUT_A == $past(OVERRIDE_LEVEL_A) && WAVE_OUTPUT_B == $past(OVERRIDE_LEVEL_B))
    else $error("override left early");
  a_keep_osc: assert property (want |=> FAST_OSC_KEEP)
    else $error("fast osc not kept");
  cover property (hit ##1 SHUTDOWN_ACTIVE_FLAG);
  cover property ($fell(SHUTDOWN_ACTIVE_FLAG));
  cover property ($rose(FAST_OSC_KEEP));
endmodule
bind complementary_wave_gen cwg_chk u_cwg_chk (.*);

// File: testbench/test_complementary_wave_gen.sv
// Purpose: self-checking bench of the generator
// Assumes: inputs change 1 ns after the rising edge
// Notes: overrides start a=0 b=1 with polarities inverted
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module test_complementary_wave_gen;
  logic CLOCK = 0, RESET = 1, GENERATOR_ENABLE_BIT = 0, AUTO_RESTART_ENABLE = 0;
  logic OVERRIDE_LEVEL_A = 0, OVERRIDE_LEVEL_B = 1, POLARITY_A = 1, POLARITY_B = 1;
  logic OUTPUT_ENABLE_A = 1, OUTPUT_ENABLE_B = 1, FAST_OSC_SELECTED = 1, INPUT_ACTIVE = 1;
  logic SHUTDOWN_SET_WRITE = 0, SHUTDOWN_CLEAR_WRITE = 0, INPUT_SOURCE = 0, shoot;
  logic [cwg_pkg::DB_W-1:0] RISE_DEADBAND_REG = 6'h03, FALL_DEADBAND_REG = 6'h02;
  logic [cwg_pkg::SRC_W-1:0] SHUTDOWN_SOURCES = 4'h0, SHUTDOWN_SELECT = 4'h5;
  logic WAVE_OUTPUT_A, WAVE_OUTPUT_B, SHUTDOWN_ACTIVE_FLAG, FAST_OSC_KEEP;
  int mismatches = 0, check_count = 0, cycles = 0, n;
  complementary_wave_gen u_complementary_wave_gen (.*);
  cwg_power_stage u_cwg_power_stage (.clk(CLOCK), .drv_a(WAVE_OUTPUT_A),
    .drv_b(WAVE_OUTPUT_B), .shoot(shoot));
  always #50 CLOCK = ~CLOCK;
  task automatic end_of_test;
    if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic step(int k);
    repeat (k) @(posedge CLOCK);
    #1;
  endtask
  task automatic t_sw_restart;
    GENERATOR_ENABLE_BIT = 1;
    step(2);
    `CHK("flag", 1'b1, SHUTDOWN_ACTIVE_FLAG)
    `CHK("a_ovr", 1'b0, WAVE_OUTPUT_A)
    `CHK("b_ovr", 1'b1, WAVE_OUTPUT_B)
    SHUTDOWN_SOURCES = 4'h4;
    SHUTDOWN_CLEAR_WRITE = 1;
    step(1);
    `CHK("flag", 1'b1, SHUTDOWN_ACTIVE_FLAG)
    SHUTDOWN_SOURCES = 4'h2;
    step(1);
    SHUTDOWN_CLEAR_WRITE = 0;
    `CHK("flag", 1'b0, SHUTDOWN_ACTIVE_FLAG)
    POLARITY_A = 0;
    POLARITY_B = 0;
    step(3);
    `CHK("a_hold", 1'b0, WAVE_OUTPUT_A)
    `CHK("b_hold", 1'b1, WAVE_OUTPUT_B)
    INPUT_SOURCE = 1;
    n = 0;
    while (WAVE_OUTPUT_A !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    `CHK("a_delay", 1'b1, n > RISE_DEADBAND_REG && n < RISE_DEADBAND_REG + 6)
    `CHK("b_run", 1'b0, WAVE_OUTPUT_B)
    INPUT_SOURCE = 0;
    step(8);
    `CHK("a_fall", 1'b0, WAVE_OUTPUT_A)
    `CHK("b_rise", 1'b1, WAVE_OUTPUT_B)
  endtask
  task automatic t_auto;
    OVERRIDE_LEVEL_A = 1;
    OVERRIDE_LEVEL_B = 0;
    SHUTDOWN_SOURCES = 4'h1;
    step(1);
    `CHK("flag", 1'b1, SHUTDOWN_ACTIVE_FLAG)
    `CHK("a_ovr", 1'b1, WAVE_OUTPUT_A)
    `CHK("b_ovr", 1'b0, WAVE_OUTPUT_B)
    AUTO_RESTART_ENABLE = 1;
    step(2);
    `CHK("flag", 1'b1, SHUTDOWN_ACTIVE_FLAG)
    SHUTDOWN_SOURCES = 4'h0;
    step(1);
    `CHK("flag", 1'b0, SHUTDOWN_ACTIVE_FLAG)
    `CHK("a_hold", 1'b1, WAVE_OUTPUT_A)
    SHUTDOWN_SET_WRITE = 1;
    step(1);
    SHUTDOWN_SET_WRITE = 0;
    `CHK("flag", 1'b1, SHUTDOWN_ACTIVE_FLAG)
  endtask
  task automatic t_gate;
    OUTPUT_ENABLE_B = 0;
    POLARITY_A = 1;
    step(2);
    INPUT_SOURCE = 1;
    step(8);
    `CHK("a_inv", 1'b0, WAVE_OUTPUT_A)
    INPUT_SOURCE = 0;
    step(8);
    `CHK("a_inv", 1'b1, WAVE_OUTPUT_A)
    `CHK("b_gate", 1'b0, WAVE_OUTPUT_B)
  endtask
  task automatic t_keep;
    FAST_OSC_SELECTED = 0;
    step(2);
    `CHK("keep", 1'b0, FAST_OSC_KEEP)
    FAST_OSC_SELECTED = 1;
    INPUT_ACTIVE = 0;
    step(2);
    `CHK("keep", 1'b0, FAST_OSC_KEEP)
    INPUT_ACTIVE = 1;
    step(2);
    `CHK("keep", 1'b1, FAST_OSC_KEEP)
    GENERATOR_ENABLE_BIT = 0;
    step(2);
    `CHK("keep", 1'b0, FAST_OSC_KEEP)
    `CHK("a_off", 1'b0, WAVE_OUTPUT_A)
    `CHK("b_off", 1'b0, WAVE_OUTPUT_B)
  endtask
  initial begin
    step(10);
    RESET = 0;
    t_sw_restart();
    t_auto();
    t_gate();
    t_keep();
    `CHK("shoot", 1'b0, shoot)
    end_of_test();
  end
endmodule
